// [hw/sas_defs.vh]
// Purpose: Offsets, field positions, reset values and timing counts of the converter sequencer
// Assumes: Word-indexed register port, 16-bit data
// Notes: Included by both design files
`ifndef SAS_DEFS_VH
`define SAS_DEFS_VH

`define SAS_ADDR_CTRL1 5'h00
`define SAS_ADDR_CTRL2 5'h01
`define SAS_ADDR_CTRL3 5'h02
`define SAS_ADDR_INSEL 5'h03
`define SAS_ADDR_PINCFG 5'h04
`define SAS_ADDR_SCAN 5'h05
`define SAS_ADDR_BUF0 5'h10

`define SAS_C1_ON 15
`define SAS_C1_TRIGGER_SOURCE_SEL_HI 7
`define SAS_C1_TRIGGER_SOURCE_SEL_LO 5
`define SAS_C1_SIMULTANEOUS_SAMPLE_SEL 3
`define SAS_C1_AUTO_SAMPLE_ENABLE 2
`define SAS_C1_SAMPLE_ACTIVE 1
`define SAS_C1_DONE 0
`define SAS_C1_IRQ 4

`define SAS_C2_SCAN 10
`define SAS_C2_BUFS 7
`define SAS_C2_CHANNELS_PER_SAMPLE_HI 9
`define SAS_C2_CHANNELS_PER_SAMPLE_LO 8
`define SAS_C2_SAMPLES_PER_IRQ_HI 5
`define SAS_C2_SAMPLES_PER_IRQ_LO 2
`define SAS_C2_BUFFER_SPLIT_MODE 1
`define SAS_C2_ALTERNATE_MUX_SEL 0

`define SAS_C3_AUTO_SAMPLE_CLOCKS_HI 12
`define SAS_C3_AUTO_SAMPLE_CLOCKS_LO 8
`define SAS_C3_ADCS_HI 5
`define SAS_C3_ADCS_LO 0

`define SAS_TRIGGER_SOURCE_SEL_SW 3'h0
`define SAS_TRIGGER_SOURCE_SEL_TMR 3'h2
`define SAS_TRIGGER_SOURCE_SEL_EXT 3'h1
`define SAS_TRIGGER_SOURCE_SEL_AUTO 3'h7

`define SAS_RST_WORD 16'h0000
`define SAS_CONV_TAD 4'hc

`endif

// [hw/sas_conv_core.v]
// Purpose: Conversion timing stand-in: counts conversion clocks and takes the settled sample
// Assumes: Enable pulse tick marks one conversion clock
// Notes: Abort drops the conversion with no result pulse
`timescale 1ns/1ns
`include "sas_defs.vh"

module sas_conv_core
#(
  parameter CONV_TAD = 12
)
(
  input wire clk,
  input wire rst_n,
  input wire tick,
  input wire start,
  input wire abort,
  input wire [9:0] sample,
  output reg busy,
  output reg done,
  output reg [9:0] result
);

  reg [3:0] count;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      count <= 4'h0;
      result <= 10'h000;
    end
    else
    begin
      done <= 1'b0;
      if (abort)
      begin
        busy <= 1'b0;
        count <= 4'h0;
      end
      else if (start && !busy)
      begin
        busy <= 1'b1;
        count <= 4'h0;
      end
      else if (busy && tick)
      begin
        if (count == CONV_TAD[3:0] - 4'h1)
        begin
          busy <= 1'b0;
          done <= 1'b1;
          // Taken at the end: the select and its sync stages settle first
          result <= sample;
        end
        else
        begin
          count <= count + 4'h1;
        end
      end
    end
  end

endmodule

// [hw/sas_sequencer.v]
// Purpose: Sequencer of a 10-bit successive-approximation converter with result buffer
// Assumes: Analog inputs arrive digitised on AIN_CODE per selected input; single clock
// Notes: Conversion timing lives in a separate stand-in module
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "sas_defs.vh"

module sas_sequencer
#(
  parameter NUM_INPUTS = 16,
  parameter DEPTH = 16
)
(
  input wire SYS_CLK,
  input wire RSTN,
  input wire [4:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [15:0] RDATA,
  input wire TIMER_TRIG,
  input wire EXT_TRIG,
  output reg [3:0] MUX_SEL0,
  output reg [3:0] MUX_SEL1,
  output reg [1:0] HOLD_CH,
  input wire [9:0] AIN_CODE,
  output wire [15:0] PIN_ANALOG,
  output wire IRQ_FLAG
);

  localparam ST_IDLE = 4'b0001;
  localparam ST_SAMPLE = 4'b0010;
  localparam ST_CONV = 4'b0100;
  localparam ST_WAIT = 4'b1000;

  reg [15:0] ctrl1;
  reg [15:0] ctrl2;
  reg [15:0] ctrl3;
  reg [15:0] insel;
  reg [15:0] pincfg;
  reg [15:0] scan;
  reg [9:0] buffer [0:DEPTH-1];
  reg [3:0] state;
  reg [5:0] div_cnt;
  reg [4:0] auto_sample_clocks_cnt;
  reg [1:0] ch_idx;
  reg [3:0] seq_cnt;
  reg [3:0] wr_ptr;
  reg half;
  reg use_b;
  reg [3:0] scan_pos;
  reg conv_start;
  reg tmr_s1, tmr_s2, tmr_d;
  reg ext_s1, ext_s2, ext_d;
  reg [9:0] ain_s1, ain_s2;
  integer i;

  wire tick = (div_cnt == ctrl3[`SAS_C3_ADCS_HI:`SAS_C3_ADCS_LO]);
  wire on = ctrl1[`SAS_C1_ON];
  wire [2:0] trigger_source_sel = ctrl1[`SAS_C1_TRIGGER_SOURCE_SEL_HI:`SAS_C1_TRIGGER_SOURCE_SEL_LO];
  wire [1:0] channels_per_sample = ctrl2[`SAS_C2_CHANNELS_PER_SAMPLE_HI:`SAS_C2_CHANNELS_PER_SAMPLE_LO];
  wire [3:0] samples_per_irq = ctrl2[`SAS_C2_SAMPLES_PER_IRQ_HI:`SAS_C2_SAMPLES_PER_IRQ_LO];
  wire [4:0] auto_sample_clocks = ctrl3[`SAS_C3_AUTO_SAMPLE_CLOCKS_HI:`SAS_C3_AUTO_SAMPLE_CLOCKS_LO];
  wire conv_done;
  wire [9:0] conv_result;

  // Channel count: 0 one, 1 two, 2/3 four
  function [1:0] last_ch;
    input [1:0] sel;
    begin
      last_ch = (sel == 2'b00) ? 2'd0 : ((sel == 2'b01) ? 2'd1 : 2'd3);
    end
  endfunction

  // Next scan input at or above a position, lowest first
  function [3:0] next_scan;
    input [15:0] mask;
    input [3:0] from;
    integer k;
    reg found;
    begin
      next_scan = from;
      found = 1'b0;
      for (k = 0; k < 16; k = k + 1)
        if (!found && k >= from && mask[k])
        begin
          next_scan = k[3:0];
          found = 1'b1;
        end
    end
  endfunction

  wire [3:0] scan_in = next_scan(scan, scan_pos);
  wire [3:0] set_ch0 = use_b ? insel[11:8] : insel[3:0];
  wire [3:0] ch0_in = (ctrl2[`SAS_C2_SCAN] && !use_b) ? scan_in : set_ch0;
  wire [3:0] base = use_b ? insel[15:12] : insel[7:4];

  // Timer and external triggers: edge detect after two-stage sync
  wire sw_trig = (trigger_source_sel == `SAS_TRIGGER_SOURCE_SEL_SW) && !ctrl1[`SAS_C1_SAMPLE_ACTIVE];
  wire hw_trig = ((trigger_source_sel == `SAS_TRIGGER_SOURCE_SEL_TMR) && tmr_s2 && !tmr_d) ||
                 ((trigger_source_sel == `SAS_TRIGGER_SOURCE_SEL_EXT) && ext_s2 && !ext_d);
  wire auto_trig = (trigger_source_sel == `SAS_TRIGGER_SOURCE_SEL_AUTO) && tick && (auto_sample_clocks_cnt >= auto_sample_clocks) && (auto_sample_clocks != 5'h00);
  wire reg_wr = WR && !on;

  assign PIN_ANALOG = ~pincfg;
  assign IRQ_FLAG = ctrl1[`SAS_C1_IRQ];

  sas_conv_core #(.CONV_TAD(`SAS_CONV_TAD)) u_core
  (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .tick(tick),
    .start(conv_start),
    .abort(!on),
    .sample(ain_s2),
    .busy(),
    .done(conv_done),
    .result(conv_result)
  );

  always @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      tmr_s1 <= 1'b0;
      tmr_s2 <= 1'b0;
      tmr_d <= 1'b0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_d <= 1'b0;
      ain_s1 <= 10'h000;
      ain_s2 <= 10'h000;
      div_cnt <= 6'h00;
    end
    else
    begin
      tmr_s1 <= TIMER_TRIG;
      tmr_s2 <= tmr_s1;
      tmr_d <= tmr_s2;
      ext_s1 <= EXT_TRIG;
      ext_s2 <= ext_s1;
      ext_d <= ext_s2;
      ain_s1 <= AIN_CODE;
      ain_s2 <= ain_s1;
      div_cnt <= tick ? 6'h00 : div_cnt + 6'h01;
    end
  end

  // Register writes; locked fields only change while off
  always @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ctrl2 <= `SAS_RST_WORD;
      ctrl3 <= `SAS_RST_WORD;
      insel <= `SAS_RST_WORD;
      pincfg <= `SAS_RST_WORD;
      scan <= `SAS_RST_WORD;
    end
    else if (WR)
    begin
      case (ADDR)
        `SAS_ADDR_CTRL2:
          if (!on)
            ctrl2 <= {WDATA[15:8], half, WDATA[6:0]};
        `SAS_ADDR_CTRL3:
          if (reg_wr)
            ctrl3 <= WDATA;
        `SAS_ADDR_INSEL: insel <= WDATA;
        `SAS_ADDR_PINCFG: pincfg <= WDATA;
        `SAS_ADDR_SCAN:
          if (reg_wr)
            scan <= WDATA;
        default: ;
      endcase
    end
    else
    begin
      ctrl2[`SAS_C2_BUFS] <= half;
    end
  end

  // Sequencer and control register one
  always @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ctrl1 <= `SAS_RST_WORD;
      state <= ST_IDLE;
      auto_sample_clocks_cnt <= 5'h00;
      ch_idx <= 2'd0;
      seq_cnt <= 4'h0;
      wr_ptr <= 4'h0;
      half <= 1'b0;
      use_b <= 1'b0;
      scan_pos <= 4'h0;
      conv_start <= 1'b0;
      MUX_SEL0 <= 4'h0;
      MUX_SEL1 <= 4'h0;
      HOLD_CH <= 2'd0;
      for (i = 0; i < DEPTH; i = i + 1)
        buffer[i] <= 10'h000;
    end
    else
    begin
      conv_start <= 1'b0;
      if (WR && ADDR == `SAS_ADDR_CTRL1)
      begin
        ctrl1[`SAS_C1_ON] <= WDATA[`SAS_C1_ON];
        ctrl1[`SAS_C1_SAMPLE_ACTIVE] <= WDATA[`SAS_C1_SAMPLE_ACTIVE];
        if (!on)
          ctrl1[7:2] <= {WDATA[7:5], ctrl1[4], WDATA[3:2]};
        if (!WDATA[`SAS_C1_IRQ])
          ctrl1[`SAS_C1_IRQ] <= 1'b0;
        if (!WDATA[`SAS_C1_DONE])
          ctrl1[`SAS_C1_DONE] <= 1'b0;
      end
      if (!on)
      begin
        // Abort wins over any coincident auto-start; buffer untouched
        state <= ST_IDLE;
        ch_idx <= 2'd0;
      end
      else
      begin
        MUX_SEL0 <= ch0_in;
        MUX_SEL1 <= base + {2'b00, ch_idx};
        case (state)
          ST_IDLE:
            if (ctrl1[`SAS_C1_SAMPLE_ACTIVE] || ctrl1[`SAS_C1_AUTO_SAMPLE_ENABLE])
            begin
              state <= ST_SAMPLE;
              ctrl1[`SAS_C1_SAMPLE_ACTIVE] <= 1'b1;
              auto_sample_clocks_cnt <= 5'h00;
              ch_idx <= 2'd0;
            end
          ST_SAMPLE:
          begin
            if (tick && auto_sample_clocks_cnt != 5'h1f)
              auto_sample_clocks_cnt <= auto_sample_clocks_cnt + 5'h01;
            if (sw_trig || hw_trig || auto_trig)
            begin
              ctrl1[`SAS_C1_SAMPLE_ACTIVE] <= 1'b0;
              conv_start <= 1'b1;
              HOLD_CH <= ch_idx;
              state <= ST_CONV;
            end
          end
          ST_CONV:
            if (conv_done)
            begin
              buffer[{half & ctrl2[`SAS_C2_BUFFER_SPLIT_MODE], 3'b000} | wr_ptr] <= conv_result;
              wr_ptr <= wr_ptr + 4'h1;
              if (ctrl2[`SAS_C2_SCAN] && ch_idx == 2'd0)
                scan_pos <= scan_in + 4'h1;
              if (ch_idx != last_ch(channels_per_sample))
              begin
                ch_idx <= ch_idx + 2'd1;
                // Simultaneous: already held, convert next without new sample
                if (ctrl1[`SAS_C1_SIMULTANEOUS_SAMPLE_SEL] && channels_per_sample != 2'b00)
                begin
                  HOLD_CH <= ch_idx + 2'd1;
                  conv_start <= 1'b1;
                  state <= ST_WAIT;
                end
                else
                begin
                  auto_sample_clocks_cnt <= 5'h00;
                  ctrl1[`SAS_C1_SAMPLE_ACTIVE] <= 1'b1;
                  state <= ST_SAMPLE;
                end
              end
              else
              begin
                ch_idx <= 2'd0;
                use_b <= ctrl2[`SAS_C2_ALTERNATE_MUX_SEL] & ~use_b;
                if (seq_cnt == samples_per_irq)
                begin
                  seq_cnt <= 4'h0;
                  wr_ptr <= 4'h0;
                  scan_pos <= 4'h0;
                  half <= ctrl2[`SAS_C2_BUFFER_SPLIT_MODE] & ~half;
                  ctrl1[`SAS_C1_IRQ] <= 1'b1;
                  ctrl1[`SAS_C1_DONE] <= 1'b1;
                  if (!ctrl2[`SAS_C2_ALTERNATE_MUX_SEL])
                    use_b <= 1'b0;
                end
                else
                begin
                  seq_cnt <= seq_cnt + 4'h1;
                end
                state <= ST_IDLE;
              end
            end
          ST_WAIT:
            state <= ST_CONV;
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  // Read data one cycle after strobe; buffer words right-justified
  always @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      RDATA <= 16'h0000;
    else if (RD)
    begin
      if (ADDR[4])
        RDATA <= {6'b00_0000, buffer[ADDR[3:0]]};
      else
        case (ADDR)
          `SAS_ADDR_CTRL1: RDATA <= ctrl1;
          `SAS_ADDR_CTRL2: RDATA <= ctrl2;
          `SAS_ADDR_CTRL3: RDATA <= ctrl3;
          `SAS_ADDR_INSEL: RDATA <= insel;
          `SAS_ADDR_PINCFG: RDATA <= pincfg;
          `SAS_ADDR_SCAN: RDATA <= scan;
          default: RDATA <= 16'h0000;
        endcase
    end
    else
      RDATA <= 16'h0000;
  end

endmodule

// [tb/sas_ain_model.sv]
// Purpose: Analog input pins seen as fixed digitised levels
// Assumes: Converted channel follows its multiplexer select
// Notes: Each input gives its own level so a wrong select shows
`timescale 1ns/1ns
module sas_ain_model (
  input wire [3:0] sel0,
  input wire [3:0] sel1,
  input wire [1:0] hold_ch,
  output wire [9:0] code
);
  wire [3:0] k = (hold_ch == 2'b00) ? sel0 : sel1;
  assign code = {k, ~k, 2'b10};
endmodule

// [tb/sas_seq_monitor.sv]
// Purpose: Port-level checks of the converter sequencer
// Assumes: Shadows of on, mode and set A follow accepted writes
// Notes: Mode shadows ignore writes made while on
`timescale 1ns/1ns
`include "sas_defs.vh"
module sas_seq_monitor (
  input wire SYS_CLK,
  input wire RSTN,
  input wire [4:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [15:0] RDATA,
  input wire [3:0] MUX_SEL0,
  input wire [1:0] HOLD_CH,
  input wire [15:0] PIN_ANALOG,
  input wire IRQ_FLAG
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  reg on_q;
  reg alt_q;
  reg scn_q;
  reg [1:0] chp_q;
  reg [3:0] ina_q;
  reg [1:0] cnt;
  wire w1 = WR && ADDR == `SAS_ADDR_CTRL1;
  wire w2 = WR && ADDR == `SAS_ADDR_CTRL2;
  wire wi = WR && ADDR == `SAS_ADDR_INSEL;
  always @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      on_q <= 1'b0;
      alt_q <= 1'b0;
      scn_q <= 1'b0;
      chp_q <= 2'b00;
      ina_q <= 4'h0;
      cnt <= 2'b00;
    end
    else
    begin
      if (w1)
        on_q <= WDATA[15];
      if (w2 && !on_q)
      begin
        alt_q <= WDATA[0];
        scn_q <= WDATA[10];
        chp_q <= WDATA[9:8];
      end
      if (wi)
        ina_q <= WDATA[3:0];
      // Settle time lets the select register catch up
      cnt <= (!on_q || wi) ? 2'b00 : ((cnt == 2'b11) ? cnt : cnt + 2'b01);
    end
  end
  sequence s_pcfg;
    WR && ADDR == `SAS_ADDR_PINCFG;
  endsequence
  chk_rd_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data not idle");
  chk_pin_write: assert property (s_pcfg |=> PIN_ANALOG == ~$past(WDATA))
    else $error("pin config not applied");
  chk_pin_hold: assert property (!(WR && ADDR == `SAS_ADDR_PINCFG) |=> $stable(PIN_ANALOG))
    else $error("pin config changed");
  chk_fmt_zero: assert property ($past(RD) && $past(ADDR[4]) |-> RDATA[15:10] == 6'h00)
    else $error("result upper bits set");
  chk_flag_read: assert property ($past(RD) && $past(ADDR) == `SAS_ADDR_CTRL1
    |-> RDATA[4] == $past(IRQ_FLAG))
    else $error("flag read mismatch");
  chk_irq_hold: assert property (IRQ_FLAG && !w1 |=> IRQ_FLAG)
    else $error("flag dropped alone");
  chk_irq_on: assert property ($rose(IRQ_FLAG) |-> on_q || $past(on_q))
    else $error("flag while off");
  chk_two_ch: assert property (chp_q == 2'b01 |-> !HOLD_CH[1])
    else $error("channel beyond two");
  chk_input_set_a: assert property (cnt == 2'b11 && !alt_q && !scn_q |-> MUX_SEL0 == ina_q)
    else $error("set A select wrong");
endmodule
bind sas_sequencer sas_seq_monitor u_mon (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .MUX_SEL0(MUX_SEL0), .HOLD_CH(HOLD_CH),
  .PIN_ANALOG(PIN_ANALOG), .IRQ_FLAG(IRQ_FLAG));

// [tb/tb_top.sv]
// Purpose: Self-checking bench of the converter sequencer
// Assumes: Read data stand one cycle after the read strobe
// Notes: Auto runs are switched off on the flag so the buffer stays put
`timescale 1ns/1ns
`include "sas_defs.vh"
module tb_top;
  reg clk = 0;
  reg rstn = 0;
  reg [4:0] addr = 0;
  reg [15:0] wdata = 0;
  reg wr = 0;
  reg rd = 0;
  reg tmr = 0;
  reg ext = 0;
  wire [15:0] rdata;
  wire [15:0] pa;
  wire [3:0] s0;
  wire [3:0] s1;
  wire [1:0] hc;
  wire [9:0] ain;
  wire irq;
  integer n_mismatch = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer i;
  integer s;
  reg [31:0] st = 32'hde5f_c666;
  reg [15:0] ins;
  reg [15:0] msk;
  reg [15:0] q;
  sas_sequencer DUT (.SYS_CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .TIMER_TRIG(tmr), .EXT_TRIG(ext), .MUX_SEL0(s0),
    .MUX_SEL1(s1), .HOLD_CH(hc), .AIN_CODE(ain), .PIN_ANALOG(pa), .IRQ_FLAG(irq));
  sas_ain_model u_ain (.sel0(s0), .sel1(s1), .hold_ch(hc), .code(ain));
  initial forever #50 clk = ~clk;
  function [15:0] xs(input d);
    begin
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      xs = st[15:0];
    end
  endfunction
  function [15:0] lv(input [3:0] k);
    lv = {6'h00, k, ~k, 2'b10};
  endfunction
  function [3:0] nth(input [15:0] m, input integer n);
    integer j;
    begin
      nth = 4'h0;
      for (j = 0; j < 16; j = j + 1)
        if (m[j] && n >= 0)
        begin
          if (n == 0)
            nth = j[3:0];
          n = n - 1;
        end
    end
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task wreg(input [4:0] a, input [15:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rc(input [4:0] a, input [15:0] m, input [15:0] e);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 q = rdata;
      chk(q & m, e);
    end
  endtask
  task stop;
    wreg(`SAS_ADDR_CTRL1, 16'h0000);
  endtask
  task waitirq;
    integer w;
    begin
      w = 0;
      // Off the edge, so a flag cleared by the last write is seen as cleared
      #1;
      while (irq !== 1'b1 && w < 400)
      begin
        @(posedge clk);
        #1 w = w + 1;
      end
      chk({15'h0000, irq}, 16'h0001);
    end
  endtask
  task run(input [15:0] c1, input [15:0] c2);
    begin
      stop;
      wreg(`SAS_ADDR_CTRL2, c2);
      wreg(`SAS_ADDR_CTRL3, 16'h0100);
      wreg(`SAS_ADDR_INSEL, ins);
      wreg(`SAS_ADDR_SCAN, msk);
      wreg(`SAS_ADDR_CTRL1, c1);
      wreg(`SAS_ADDR_CTRL1, c1 | 16'h8002);
      repeat (4) @(posedge clk);
      if (c1[7:5] == `SAS_TRIGGER_SOURCE_SEL_SW)
        wreg(`SAS_ADDR_CTRL1, c1 | 16'h8000);
      ext <= (c1[7:5] == `SAS_TRIGGER_SOURCE_SEL_EXT);
      tmr <= (c1[7:5] == `SAS_TRIGGER_SOURCE_SEL_TMR);
      repeat (3) @(posedge clk);
      ext <= 1'b0;
      tmr <= 1'b0;
      waitirq;
    end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      end_of_test;
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 6; i = i + 1)
      rc(i[4:0], 16'hffff, `SAS_RST_WORD);
    rc(5'h08, 16'hffff, 16'h0000);
    chk(pa, 16'hffff);
    ins = xs(0);
    wreg(`SAS_ADDR_PINCFG, ins);
    #1 chk(pa, ~ins);
    rc(`SAS_ADDR_PINCFG, 16'hffff, ins);
    $display("test registers done");
    for (i = 0; i < 4; i = i + 1)
    begin
      ins = xs(0);
      msk = 16'h0000;
      run({8'h00, (i == 3) ? 3'h7 : i[2:0], 5'h00}, 16'h0000);
      rc(`SAS_ADDR_CTRL1, 16'h0011, 16'h0011);
      stop;
      rc(`SAS_ADDR_BUF0, 16'hffff, lv(ins[3:0]));
    end
    msk = lv(ins[3:0]);
    ins = xs(0);
    wreg(`SAS_ADDR_INSEL, ins);
    wreg(`SAS_ADDR_CTRL1, 16'h00e0);
    wreg(`SAS_ADDR_CTRL1, 16'h80e2);
    repeat (6) @(posedge clk);
    stop;
    repeat (20) @(posedge clk);
    #1 chk({15'h0000, irq}, 16'h0000);
    rc(`SAS_ADDR_BUF0, 16'hffff, msk);
    $display("test triggers done");
    for (i = 0; i < 3; i = i + 1)
    begin
      ins = xs(0);
      msk = 16'h0000;
      run(16'h00e4 | {12'h000, i[0], 3'h0}, (i == 2) ? 16'h0200 : 16'h0100);
      stop;
      rc(`SAS_ADDR_BUF0, 16'hffff, lv(ins[3:0]));
      rc(`SAS_ADDR_BUF0 + 5'h01, 16'hffff, lv(ins[7:4] + 4'h1));
      if (i == 2)
        for (s = 2; s < 4; s = s + 1)
          rc(`SAS_ADDR_BUF0 + s[4:0], 16'hffff, lv(ins[7:4] + s[3:0]));
    end
    ins = xs(0);
    run(16'h00e4, 16'h0005);
    stop;
    rc(`SAS_ADDR_BUF0, 16'hffff, lv(ins[3:0]));
    rc(`SAS_ADDR_BUF0 + 5'h01, 16'hffff, lv(ins[11:8]));
    $display("test channels done");
    for (s = 0; s < 2; s = s + 1)
    begin
      ins = xs(0);
      msk = (s == 0) ? 16'h8421 : (xs(0) | 16'h8421);
      run(16'h00e4, 16'h040c);
      stop;
      for (i = 0; i < 4; i = i + 1)
        rc(`SAS_ADDR_BUF0 + i[4:0], 16'hffff, lv(nth(msk, i)));
    end
    $display("test scan done");
    ins = xs(0);
    msk = 16'h0000;
    run(16'h00e4, 16'h001e);
    rc(`SAS_ADDR_CTRL2, 16'h0080, 16'h0080);
    wreg(`SAS_ADDR_CTRL2, 16'h0000);
    rc(`SAS_ADDR_CTRL2, 16'h047f, 16'h001e);
    wreg(`SAS_ADDR_CTRL1, 16'h80e6);
    waitirq;
    stop;
    wreg(`SAS_ADDR_BUF0, 16'h03ff);
    for (i = 0; i < 16; i = i + 1)
      rc(`SAS_ADDR_BUF0 + i[4:0], 16'hffff, lv(ins[3:0]));
    $display("test split done");
    end_of_test;
  end
endmodule
